// ### bench/ciie_core_tb.sv
// Self-checking testbench for the increment, idle and return core.
`timescale 1ns/100ps
`default_nettype none
module ciie_core_tb;
	localparam logic [7:0] FL = ciie_pkg::OFS_FLAGS;
	localparam logic [7:0] SPA = ciie_pkg::OFS_SP;
	localparam logic [7:0] IPH = ciie_pkg::OFS_IP_HI;
	localparam logic [7:0] IPL = ciie_pkg::OFS_IP_LO;
	localparam logic [7:0] SYA = ciie_pkg::OFS_SYM;
	logic ref_clk;
	logic srst;
	logic [15:0] fetch_addr;
	logic fetch_req;
	logic fetch_valid;
	logic [7:0] fetch_data;
	logic irq_req;
	logic fast_sel;
	logic cpu_clk_en;
	logic instr_done;
	logic [7:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_we;
	logic bus_re;
	logic [7:0] bus_rdata;
	logic [7:0] rv;
	int errors;
	int n_tests;

	ciie_core DUT (
		.ref_clk(ref_clk),
		.srst(srst),
		.fetch_addr(fetch_addr),
		.fetch_req(fetch_req),
		.fetch_valid(fetch_valid),
		.fetch_data(fetch_data),
		.irq_req(irq_req),
		.fast_sel(fast_sel),
		.cpu_clk_en(cpu_clk_en),
		.instr_done(instr_done),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_we(bus_we),
		.bus_re(bus_re),
		.bus_rdata(bus_rdata)
	);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("Counts: %0d compares, %0d mismatches", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic timed_out();
		errors++;
		$display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
		tally_and_finish();
	endtask

	// An idle cycle follows each write so the strobe is never driven twice
	// in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_we <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_we <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Read data is taken at the falling edge inside the cycle after the strobe.
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		bus_re <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_re <= 1'b0;
		@(negedge ref_clk);
		rv = bus_rdata;
		chk({8'h00, rv}, {8'h00, e});
		@(posedge ref_clk);
	endtask

	// Offers one or two program bytes and returns at the edge after retirement.
	task automatic run_op(input logic [7:0] op, input logic [7:0] arg,
		input bit two, input int ncyc);
		int n;
		fetch_valid <= 1'b1;
		fetch_data <= op;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (fetch_req !== 1'b1 && n < 40);
		if (n == 40) timed_out();
		@(posedge ref_clk);
		if (two) begin
			fetch_data <= arg;
			@(posedge ref_clk);
		end
		fetch_valid <= 1'b0;
		for (n = two ? 2 : 1; n < 40; n++) begin
			@(negedge ref_clk);
			if (instr_done === 1'b1) break;
		end
		if (n == 40) timed_out();
		@(posedge ref_clk);
		chk(16'(n), 16'(ncyc));
	endtask

	task automatic pulse_irq();
		irq_req <= 1'b1;
		@(posedge ref_clk);
		irq_req <= 1'b0;
	endtask

	task automatic t_reset();
		rchk(FL, ciie_pkg::FLAGS_RST);
		rchk(SPA, ciie_pkg::SP_RST);
		rchk(IPH, ciie_pkg::IP_RST[15:8]);
		rchk(IPL, ciie_pkg::IP_RST[7:0]);
		rchk(SYA, ciie_pkg::SYM_RST);
		$display("test reset done");
	endtask

	task automatic t_inc();
		wr({ciie_pkg::WORK_BASE, 4'h3}, 8'h7f);
		wr(FL, 8'h8c);
		run_op(8'h3e, 8'h00, 1'b0, 4);
		rchk(8'hc3, 8'h80);
		rchk(FL, 8'hbc);
		wr(8'hc3, 8'hff);
		wr(FL, 8'h70);
		run_op(8'h3e, 8'h00, 1'b0, 4);
		rchk(8'hc3, 8'h00);
		rchk(FL, 8'h40);
		wr(8'h40, 8'h0c);
		run_op(8'h20, 8'h40, 1'b1, 4);
		rchk(8'h40, 8'h0d);
		rchk(FL, 8'h00);
		wr(8'h50, 8'h1b);
		wr(8'h1b, 8'h0f);
		run_op(8'h21, 8'h50, 1'b1, 4);
		rchk(8'h1b, 8'h10);
		rchk(8'h50, 8'h1b);
		$display("test byte increment done");
	endtask

	// A zero word result is checked from both bytes and from the Z flag.
	task automatic t_word_add_one();
		logic [7:0] hi;
		wr(8'hc2, 8'h0f);
		wr(8'hc3, 8'hff);
		wr(FL, 8'h8c);
		run_op(8'ha0, 8'hc2, 1'b1, 8);
		rchk(8'hc2, 8'h10);
		rchk(8'hc3, 8'h00);
		rchk(FL, 8'h8c);
		wr(8'h60, 8'h20);
		wr(8'h20, 8'h7f);
		wr(8'h21, 8'hff);
		run_op(8'ha1, 8'h60, 1'b1, 8);
		rchk(8'h20, 8'h80);
		rchk(8'h21, 8'h00);
		rchk(FL, 8'hbc);
		wr(8'hc4, 8'hff);
		wr(8'hc5, 8'hff);
		run_op(8'ha0, 8'hc5, 1'b1, 8);
		rchk(8'hc4, 8'h00);
		hi = rv;
		rchk(8'hc5, 8'h00);
		chk({8'h00, hi | rv}, 16'h0000);
		rchk(FL, 8'hcc);
		$display("test word increment done");
	endtask

	task automatic t_service_return();
		wr(SPA, 8'h80);
		wr(8'h80, 8'ha4);
		wr(8'h81, 8'h12);
		wr(8'h82, 8'h34);
		wr(FL, 8'h00);
		wr(SYA, 8'h00);
		run_op(8'hbf, 8'h00, 1'b0, 10);
		chk(fetch_addr, 16'h1234);
		rchk(FL, 8'ha4);
		rchk(SPA, 8'h83);
		rchk(SYA, 8'h01);
		wr(IPH, 8'h56);
		wr(IPL, 8'h78);
		wr(FL, 8'h02);
		wr(SYA, 8'h00);
		run_op(8'hbf, 8'h00, 1'b0, 6);
		chk(fetch_addr, 16'h5678);
		rchk(IPH, 8'h12);
		rchk(IPL, 8'h35);
		rchk(SYA, 8'h01);
		rchk(SPA, 8'h83);
		rchk(FL, 8'h00);
		$display("test service return done");
	endtask

	// The first request arrives with service disabled and must only pend.
	task automatic t_irq();
		wr(IPH, 8'h01);
		wr(IPL, 8'h00);
		wr(SYA, 8'h00);
		fast_sel <= 1'b1;
		pulse_irq();
		run_op(8'hff, 8'h00, 1'b0, 4);
		chk(fetch_addr, 16'h5679);
		wr(SYA, 8'h01);
		run_op(8'hff, 8'h00, 1'b0, 4);
		repeat (3) @(posedge ref_clk);
		chk(fetch_addr, 16'h0100);
		rchk(IPH, 8'h56);
		rchk(IPL, 8'h7a);
		rchk(SYA, 8'h00);
		wr(SPA, 8'h90);
		fast_sel <= 1'b0;
		wr(SYA, 8'h01);
		pulse_irq();
		run_op(8'hff, 8'h00, 1'b0, 4);
		repeat (3) @(posedge ref_clk);
		chk(fetch_addr, ciie_pkg::VEC_ADDR);
		rchk(SPA, 8'h8d);
		rchk(8'h8f, 8'h01);
		rchk(8'h8e, 8'h01);
		rchk(8'h8d, 8'h02);
		rchk(SYA, 8'h00);
		$display("test interrupt entry done");
	endtask

	task automatic t_idle();
		wr(FL, 8'ha5);
		run_op(ciie_pkg::OPC_IDLE, 8'h00, 1'b0, 4);
		repeat (3) @(posedge ref_clk);
		chk({15'h0000, cpu_clk_en}, 16'h0000);
		pulse_irq();
		@(negedge ref_clk);
		chk({15'h0000, cpu_clk_en}, 16'h0001);
		@(posedge ref_clk);
		rchk(FL, 8'ha5);
		run_op(ciie_pkg::OPC_IDLE, 8'h00, 1'b0, 4);
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		chk({15'h0000, cpu_clk_en}, 16'h0001);
		chk({15'h0000, instr_done}, 16'h0000);
		chk({15'h0000, fetch_req}, 16'h0000);
		@(negedge ref_clk);
		chk({15'h0000, fetch_req}, 16'h0001);
		chk(fetch_addr, ciie_pkg::PC_RST);
		@(posedge ref_clk);
		rchk(FL, ciie_pkg::FLAGS_RST);
		$display("test idle done");
	endtask

	initial begin
		srst = 1'b1;
		fetch_valid = 1'b0;
		fetch_data = 8'h00;
		irq_req = 1'b0;
		fast_sel = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		bus_we = 1'b0;
		bus_re = 1'b0;
		errors = 0;
		n_tests = 0;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_inc();
		t_word_add_one();
		t_service_return();
		t_irq();
		t_idle();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ### inc/ciie_pkg.sv
// Package of constants and types for the increment, idle and return core.
package ciie_pkg;

	// Register map of the core-side registers.
	localparam logic [7:0] OFS_FLAGS = 8'hd5;
	localparam logic [7:0] OFS_SP = 8'hd9;
	localparam logic [7:0] OFS_IP_HI = 8'hda;
	localparam logic [7:0] OFS_IP_LO = 8'hdb;
	localparam logic [7:0] OFS_SYM = 8'hde;

	// Field positions.
	localparam int SYM_GIE = 0;
	localparam logic [3:0] WORK_BASE = 4'hc;

	// Reset values.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] SYM_RST = 8'h00;
	localparam logic [7:0] SP_RST = 8'h00;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] IP_RST = 16'h0000;
	localparam logic [15:0] VEC_ADDR = 16'h0000;

	// Opcodes.
	localparam logic [7:0] OPC_IDLE = 8'h6f;
	localparam logic [3:0] OPC_INC_LO = 4'he;
	localparam logic [7:0] OPC_INC_R = 8'h20;
	localparam logic [7:0] OPC_INC_IR = 8'h21;
	localparam logic [7:0] OPC_WORD_ADD_ONE_RR = 8'ha0;
	localparam logic [7:0] OPC_WORD_ADD_ONE_IR = 8'ha1;
	localparam logic [7:0] OPC_SERVICE_RETURN = 8'hbf;

	// Cycle counts per instruction.
	localparam logic [3:0] CYC_IDLE = 4'h4;
	localparam logic [3:0] CYC_INC = 4'h4;
	localparam logic [3:0] CYC_WORD_ADD_ONE = 4'h8;
	localparam logic [3:0] CYC_SERVICE_RETURN_N = 4'ha;
	localparam logic [3:0] CYC_SERVICE_RETURN_F = 4'h6;
	localparam logic [3:0] CYC_NOP = 4'h4;

	// Condition flags, bit 7 down to bit 0.
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
		logic fast_service_status;
		logic bank;
	} ciie_flags_t;

	typedef struct packed {
		logic [15:0] sum;
		logic zero;
		logic sign;
		logic ovf;
	} ciie_incr_res_t;

	typedef enum {
		S_FETCH_OP, S_FETCH_ARG, S_ADDR, S_COMMIT, S_WAIT, S_SLEEP, S_ENTRY
	} ciie_state_t;

	typedef enum {K_IDLE, K_INC, K_WORD_ADD_ONE, K_SERVICE_RETURN, K_NOP} ciie_kind_t;

endpackage

// ### logic/ciie_core.sv
// Execution core for idle, byte and word increment and interrupt return.
//
// Function
// - Idle opcode gates the CPU clock off.
// - Interrupt request or reset ends idle.
// - Idle leaves all flags unchanged.
// - Byte increment adds one in place.
// - Byte increment sets Z, S, V; D, H kept.
// - Word increment on even pair, carry propagates.
// - Word flags from 16 bits; C, D, H kept.
// - Normal return pops flags, PC, sets enable.
// - Normal return only when fast bit clear.
// - Fast return swaps PC/IP, restores shadow flags.
// - Fast entry swaps PC and IP.
// - Global enable gates service; requests stay pending.
`timescale 1ns/100ps
`default_nettype none
module ciie_core (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Instruction fetch
	output logic [15:0] fetch_addr,
	output logic fetch_req,
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_data,
	// Interrupt side
	input wire logic irq_req,
	input wire logic fast_sel,
	// Core status
	output logic cpu_clk_en,
	output logic instr_done,
	// Register port
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_we,
	input wire logic bus_re,
	output logic [7:0] bus_rdata
);
	ciie_pkg::ciie_state_t state_r, state_nxt, after_retire;
	ciie_pkg::ciie_kind_t kind_r, dec_kind;
	ciie_pkg::ciie_flags_t flags_r, shadow_r;
	ciie_pkg::ciie_incr_res_t res;
	logic [7:0] regs [256];
	logic [7:0] opc_r, arg_r, ea_r, sp_r, sym_r, rdata_r;
	logic [15:0] pc_r, ip_r, opnd;
	logic [3:0] cyc_r, tot_r, dec_tot;
	logic dec_two, fast_r, pend_r, run_r, done_r, fetch_req_r;
	logic take_op, take_arg, commit, entry_go, retire, svc;

	assign fetch_addr = pc_r;
	assign fetch_req = fetch_req_r;
	assign cpu_clk_en = run_r;
	assign instr_done = done_r;
	assign bus_rdata = rdata_r;

	assign take_op = (state_r == ciie_pkg::S_FETCH_OP) && fetch_req_r &&
		fetch_valid;
	assign take_arg = (state_r == ciie_pkg::S_FETCH_ARG) && fetch_req_r &&
		fetch_valid;
	// A register write from software owns the cycle; the core waits.
	assign commit = (state_r == ciie_pkg::S_COMMIT) && !bus_we;
	assign entry_go = (state_r == ciie_pkg::S_ENTRY) && !bus_we;
	assign retire = ((state_r == ciie_pkg::S_WAIT) || commit) &&
		(cyc_r >= tot_r - 4'h1);
	assign svc = sym_r[ciie_pkg::SYM_GIE] && (pend_r || irq_req);

	// Opcode decode into kind, length and cycle count.
	always_comb begin
		dec_kind = ciie_pkg::K_NOP;
		dec_tot = ciie_pkg::CYC_NOP;
		dec_two = 1'b0;
		if (fetch_data == ciie_pkg::OPC_IDLE) begin
			dec_kind = ciie_pkg::K_IDLE;
			dec_tot = ciie_pkg::CYC_IDLE;
		end else if (fetch_data[3:0] == ciie_pkg::OPC_INC_LO) begin
			dec_kind = ciie_pkg::K_INC;
			dec_tot = ciie_pkg::CYC_INC;
		end else if (fetch_data == ciie_pkg::OPC_INC_R ||
			fetch_data == ciie_pkg::OPC_INC_IR) begin
			dec_kind = ciie_pkg::K_INC;
			dec_tot = ciie_pkg::CYC_INC;
			dec_two = 1'b1;
		end else if (fetch_data == ciie_pkg::OPC_WORD_ADD_ONE_RR ||
			fetch_data == ciie_pkg::OPC_WORD_ADD_ONE_IR) begin
			dec_kind = ciie_pkg::K_WORD_ADD_ONE;
			dec_tot = ciie_pkg::CYC_WORD_ADD_ONE;
			dec_two = 1'b1;
		end else if (fetch_data == ciie_pkg::OPC_SERVICE_RETURN) begin
			dec_kind = ciie_pkg::K_SERVICE_RETURN;
			dec_tot = ciie_pkg::CYC_SERVICE_RETURN_N;
		end
	end

	// Next state.
	always_comb begin
		if (kind_r == ciie_pkg::K_IDLE)
			after_retire = ciie_pkg::S_SLEEP;
		else if (svc)
			after_retire = ciie_pkg::S_ENTRY;
		else
			after_retire = ciie_pkg::S_FETCH_OP;
		state_nxt = state_r;
		unique case (state_r)
		ciie_pkg::S_FETCH_OP: begin
			if (take_op)
				state_nxt = dec_two ? ciie_pkg::S_FETCH_ARG : ciie_pkg::S_ADDR;
		end
		ciie_pkg::S_FETCH_ARG: begin
			if (take_arg)
				state_nxt = ciie_pkg::S_ADDR;
		end
		ciie_pkg::S_ADDR: state_nxt = ciie_pkg::S_COMMIT;
		ciie_pkg::S_COMMIT: begin
			if (retire)
				state_nxt = after_retire;
			else if (commit)
				state_nxt = ciie_pkg::S_WAIT;
		end
		ciie_pkg::S_WAIT: begin
			if (retire)
				state_nxt = after_retire;
		end
		ciie_pkg::S_SLEEP: begin
			if (irq_req)
				state_nxt = svc ? ciie_pkg::S_ENTRY : ciie_pkg::S_FETCH_OP;
		end
		ciie_pkg::S_ENTRY: begin
			if (entry_go)
				state_nxt = ciie_pkg::S_FETCH_OP;
		end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r <= ciie_pkg::S_FETCH_OP;
			fetch_req_r <= 1'b0;
			run_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fetch_req_r <= (state_nxt == ciie_pkg::S_FETCH_OP) ||
				(state_nxt == ciie_pkg::S_FETCH_ARG);
			run_r <= (state_nxt != ciie_pkg::S_SLEEP);
			done_r <= retire;
		end
	end

	// Instruction bookkeeping and cycle count.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			kind_r <= ciie_pkg::K_NOP;
			opc_r <= 8'h00;
			arg_r <= 8'h00;
			tot_r <= ciie_pkg::CYC_NOP;
			cyc_r <= 4'h0;
		end else begin
			if (take_op) begin
				kind_r <= dec_kind;
				opc_r <= fetch_data;
				tot_r <= dec_tot;
				cyc_r <= 4'h1;
			end else begin
				if (cyc_r != 4'hf)
					cyc_r <= cyc_r + 4'h1;
				if (state_r == ciie_pkg::S_ADDR &&
					kind_r == ciie_pkg::K_SERVICE_RETURN && flags_r.fast_service_status)
					tot_r <= ciie_pkg::CYC_SERVICE_RETURN_F;
			end
			if (take_arg)
				arg_r <= fetch_data;
		end
	end

	// Effective address and the choice of return form.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ea_r <= 8'h00;
			fast_r <= 1'b0;
		end else if (state_r == ciie_pkg::S_ADDR) begin
			fast_r <= flags_r.fast_service_status;
			if (opc_r[3:0] == ciie_pkg::OPC_INC_LO)
				ea_r <= {ciie_pkg::WORK_BASE, opc_r[7:4]};
			else if (opc_r == ciie_pkg::OPC_INC_R)
				ea_r <= arg_r;
			else if (opc_r == ciie_pkg::OPC_INC_IR)
				ea_r <= regs[arg_r];
			else if (opc_r == ciie_pkg::OPC_WORD_ADD_ONE_RR)
				ea_r <= {arg_r[7:1], 1'b0};
			else if (opc_r == ciie_pkg::OPC_WORD_ADD_ONE_IR)
				ea_r <= {regs[arg_r][7:1], 1'b0};
		end
	end

	assign opnd = (kind_r == ciie_pkg::K_WORD_ADD_ONE) ?
		{regs[ea_r], regs[ea_r | 8'h01]} : {8'h00, regs[ea_r]};

	ciie_incr u_incr (
		.opnd(opnd),
		.word_sel(kind_r == ciie_pkg::K_WORD_ADD_ONE),
		.res(res)
	);

	// Register file and internal stack; the even byte holds the high half.
	always_ff @(posedge ref_clk) begin
		if (bus_we) begin
			regs[bus_addr] <= bus_wdata;
		end else if (commit && kind_r == ciie_pkg::K_INC) begin
			regs[ea_r] <= res.sum[7:0];
		end else if (commit && kind_r == ciie_pkg::K_WORD_ADD_ONE) begin
			regs[ea_r] <= res.sum[15:8];
			regs[ea_r | 8'h01] <= res.sum[7:0];
		end else if (entry_go && !fast_sel) begin
			regs[sp_r - 8'h01] <= pc_r[7:0];
			regs[sp_r - 8'h02] <= pc_r[15:8];
			regs[sp_r - 8'h03] <= flags_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flags_r <= ciie_pkg::FLAGS_RST;
		end else if (bus_we && bus_addr == ciie_pkg::OFS_FLAGS) begin
			flags_r <= bus_wdata;
		end else if (commit) begin
			unique case (kind_r)
			ciie_pkg::K_INC, ciie_pkg::K_WORD_ADD_ONE: begin
				flags_r.z <= res.zero;
				flags_r.s <= res.sign;
				flags_r.v <= res.ovf;
			end
			ciie_pkg::K_SERVICE_RETURN: begin
				if (fast_r) begin
					flags_r <= shadow_r;
					flags_r.fast_service_status <= 1'b0;
				end else begin
					flags_r <= regs[sp_r];
				end
			end
			ciie_pkg::K_IDLE, ciie_pkg::K_NOP: flags_r <= flags_r;
			endcase
		end else if (entry_go && fast_sel) begin
			flags_r.fast_service_status <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			shadow_r <= ciie_pkg::FLAGS_RST;
		else if (entry_go && fast_sel)
			shadow_r <= flags_r;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sym_r <= ciie_pkg::SYM_RST;
		end else if (bus_we && bus_addr == ciie_pkg::OFS_SYM) begin
			sym_r <= bus_wdata;
		end else if (commit && kind_r == ciie_pkg::K_SERVICE_RETURN) begin
			sym_r[ciie_pkg::SYM_GIE] <= 1'b1;
		end else if (entry_go) begin
			sym_r[ciie_pkg::SYM_GIE] <= 1'b0;
		end
	end

	// A request arriving in the service cycle stays pending.
	always_ff @(posedge ref_clk) begin
		if (srst)
			pend_r <= 1'b0;
		else if (irq_req)
			pend_r <= 1'b1;
		else if (entry_go)
			pend_r <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sp_r <= ciie_pkg::SP_RST;
		end else if (bus_we && bus_addr == ciie_pkg::OFS_SP) begin
			sp_r <= bus_wdata;
		end else if (commit && kind_r == ciie_pkg::K_SERVICE_RETURN && !fast_r) begin
			sp_r <= sp_r + 8'h03;
		end else if (entry_go && !fast_sel) begin
			sp_r <= sp_r - 8'h03;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pc_r <= ciie_pkg::PC_RST;
		end else if (take_op || take_arg) begin
			pc_r <= pc_r + 16'h0001;
		end else if (commit && kind_r == ciie_pkg::K_SERVICE_RETURN) begin
			if (fast_r)
				pc_r <= ip_r;
			else
				pc_r <= {regs[sp_r + 8'h01], regs[sp_r + 8'h02]};
		end else if (entry_go) begin
			pc_r <= fast_sel ? ip_r : ciie_pkg::VEC_ADDR;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ip_r <= ciie_pkg::IP_RST;
		end else if (bus_we && bus_addr == ciie_pkg::OFS_IP_HI) begin
			ip_r[15:8] <= bus_wdata;
		end else if (bus_we && bus_addr == ciie_pkg::OFS_IP_LO) begin
			ip_r[7:0] <= bus_wdata;
		end else if (commit && kind_r == ciie_pkg::K_SERVICE_RETURN && fast_r) begin
			ip_r <= pc_r;
		end else if (entry_go && fast_sel) begin
			ip_r <= pc_r;
		end
	end

	// Read data stand for one cycle only.
	always_ff @(posedge ref_clk) begin
		if (srst || !bus_re)
			rdata_r <= 8'h00;
		else if (bus_addr == ciie_pkg::OFS_FLAGS)
			rdata_r <= flags_r;
		else if (bus_addr == ciie_pkg::OFS_SYM)
			rdata_r <= sym_r;
		else if (bus_addr == ciie_pkg::OFS_SP)
			rdata_r <= sp_r;
		else if (bus_addr == ciie_pkg::OFS_IP_HI)
			rdata_r <= ip_r[15:8];
		else if (bus_addr == ciie_pkg::OFS_IP_LO)
			rdata_r <= ip_r[7:0];
		else
			rdata_r <= regs[bus_addr];
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	a_idle_clk_gate: assert property (
		(retire && kind_r == ciie_pkg::K_IDLE) |=> !cpu_clk_en)
		else $error("idle did not gate the clock");
	a_idle_wake: assert property (
		(state_r == ciie_pkg::S_SLEEP && irq_req) |=> cpu_clk_en)
		else $error("idle not released by request");
	a_idle_flags: assert property (
		(commit && kind_r == ciie_pkg::K_IDLE) |=> $stable(flags_r))
		else $error("idle changed flags");
	a_inc_value: assert property (
		(commit && kind_r == ciie_pkg::K_INC) |=>
		regs[$past(ea_r)] == 8'($past(regs[ea_r]) + 8'h01))
		else $error("byte increment wrong");
	a_inc_flags: assert property (
		(commit && kind_r == ciie_pkg::K_INC) |=>
		flags_r.v == ($past(regs[ea_r]) == 8'h7f) &&
		flags_r.z == ($past(regs[ea_r]) == 8'hff) &&
		flags_r.s == ($past(regs[ea_r]) >= 8'h7f &&
		$past(regs[ea_r]) != 8'hff) &&
		flags_r.d == $past(flags_r.d) && flags_r.h == $past(flags_r.h))
		else $error("byte increment flags wrong");
	a_inc_cycles: assert property (
		(take_op && fetch_data[3:0] == ciie_pkg::OPC_INC_LO) ##1
		!bus_we [*3] |=> instr_done)
		else $error("byte increment not four cycles");
	a_word_add_one_carry: assert property (
		(commit && kind_r == ciie_pkg::K_WORD_ADD_ONE) |=>
		{regs[$past(ea_r)], regs[$past(ea_r) | 8'h01]} == $past(opnd) + 16'h1)
		else $error("word increment wrong");
	a_word_add_one_flags: assert property (
		(commit && kind_r == ciie_pkg::K_WORD_ADD_ONE) |=>
		$stable(flags_r.c) && $stable(flags_r.d) && $stable(flags_r.h) &&
		flags_r.z == ($past(opnd) == 16'hffff))
		else $error("word increment flags wrong");
	a_service_return_normal: assert property (
		(commit && kind_r == ciie_pkg::K_SERVICE_RETURN && !fast_r) |=>
		sp_r == 8'($past(sp_r) + 8'h03) && sym_r[ciie_pkg::SYM_GIE])
		else $error("normal return wrong");
	a_service_return_fast: assert property (
		(commit && kind_r == ciie_pkg::K_SERVICE_RETURN && fast_r) |=>
		pc_r == $past(ip_r) && ip_r == $past(pc_r) && !flags_r.fast_service_status)
		else $error("fast return wrong");
	a_fast_entry: assert property (
		(entry_go && fast_sel) |=> pc_r == $past(ip_r) && flags_r.fast_service_status)
		else $error("fast entry did not swap");
	a_gie_hold: assert property (
		(!sym_r[ciie_pkg::SYM_GIE] &&
		state_r != ciie_pkg::S_ENTRY) |=> state_r != ciie_pkg::S_ENTRY)
		else $error("request serviced while disabled");

	c_idle_wake: cover property (
		state_r == ciie_pkg::S_SLEEP ##1 state_r != ciie_pkg::S_SLEEP);
	c_word_add_one_carry: cover property (
		commit && kind_r == ciie_pkg::K_WORD_ADD_ONE && opnd[7:0] == 8'hff);
	c_service_return_fast: cover property (commit && kind_r == ciie_pkg::K_SERVICE_RETURN && fast_r);
	c_service_return_norm: cover property (commit && kind_r == ciie_pkg::K_SERVICE_RETURN && !fast_r);
endmodule
`default_nettype wire

// ### logic/ciie_incr.sv
// Byte and word incrementer with zero, sign and overflow results.
`timescale 1ns/100ps
`default_nettype none
module ciie_incr (
	// Operand
	input wire logic [15:0] opnd,
	input wire logic word_sel,
	// Result
	output ciie_pkg::ciie_incr_res_t res
);
	logic [15:0] sum16;
	logic [7:0] sum8;

	always_comb begin
		sum16 = opnd + 16'h0001;
		sum8 = opnd[7:0] + 8'h01;
		if (word_sel) begin
			res.sum = sum16;
			res.zero = (sum16 == 16'h0000);
			res.sign = sum16[15];
			res.ovf = (opnd == 16'h7fff);
		end else begin
			res.sum = {8'h00, sum8};
			res.zero = (sum8 == 8'h00);
			res.sign = sum8[7];
			res.ovf = (opnd[7:0] == 8'h7f);
		end
	end
endmodule
`default_nettype wire
